// file: rtl/dma_block_and_request_transfer.sv
// Two-channel DMA transfer sequencer with Avalon-MM registers
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "dma_cfg.svh"
module dma_block_and_request_transfer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] usb_dma_request_n,
  output logic busRequest,
  input wire logic busGrant,
  output dma_pkg::mem_req_t memReq,
  input wire logic [15:0] memReadData,
  input wire logic memWaitRequest,
  output logic irq
);
  import dma_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [`DMA_ADDR_W-1:0] stepAddr(input logic [`DMA_ADDR_W-1:0] a, input logic en,
                                                        input logic dir, input logic word);
    logic [`DMA_ADDR_W-1:0] stride;
    stride = word ? 24'h000002 : 24'h000001;
    if (!en) begin
      stepAddr = a;
    end else if (dir) begin
      stepAddr = a - stride;
    end else begin
      stepAddr = a + stride;
    end
  endfunction

  function automatic logic [1:0] laneEnable(input logic word, input logic a0);
    if (word) begin
      laneEnable = 2'h3;
    end else begin
      laneEnable = a0 ? 2'h2 : 2'h1;
    end
  endfunction

  // ==========================================================
  // State
  channel_control_t ctrl_r [0:1];
  logic [`DMA_ADDR_W-1:0] srcAddress_r [0:1];
  logic [`DMA_ADDR_W-1:0] dstAddress_r [0:1];
  logic [`DMA_ADDR_W-1:0] srcBase_r [0:1];
  logic [`DMA_ADDR_W-1:0] dstBase_r [0:1];
  logic [7:0] blockRemainingCount_r [0:1];
  logic [7:0] blockSizeReload_r [0:1];
  logic [15:0] blockCounter_r [0:1];
  logic [1:0] endEvent_r;
  logic blockEnd_r;
  logic activeCh_r;
  xfer_state_t state_r;
  logic busRequest_r;
  mem_req_t memReq_r;
  logic waitReq_r;
  logic [31:0] readData_r;

  logic [1:0] reqLevel;
  logic [1:0] pending;
  logic [1:0] status;
  logic [1:0] mask;
  logic [1:0] endIntEnVec;
  logic [1:0] readClear;
  logic access;
  logic wrAccess;
  logic inChannel;
  logic regCh;
  logic [4:0] regOff;
  logic maskWrite;
  channel_control_t actCtrl;
  logic continueXfer;

  // ==========================================================
  // Request synchroniser and interrupt block
  req_sync u_req_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .asyncIn(usb_dma_request_n),
    .syncOut(reqLevel)
  );

  dma_irq_ctrl u_irq (
    .ref_clk(ref_clk),
    .rst(rst),
    .endEvent(endEvent_r),
    .endIntEnable(endIntEnVec),
    .readClear(readClear),
    .maskWrite(maskWrite),
    .maskData(avs_writedata[1:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  // ==========================================================
  // Bus slave decode
  always_comb begin
    access = (avs_read | avs_write) & ~waitReq_r;
    wrAccess = access & avs_write;
    inChannel = ~avs_address[`REG_GLOBAL_BIT] & ~avs_address[7];
    regCh = avs_address[`REG_CH_BIT];
    regOff = avs_address[4:0];
    maskWrite = wrAccess & (avs_address == `REG_MASK_OFF);
    // Only bits that were shown to software are cleared
    readClear = (access & avs_read & (avs_address == `REG_STATUS_OFF)) ? readData_r[1:0] : 2'h0;
    endIntEnVec = {ctrl_r[1].endIntEnable, ctrl_r[0].endIntEnable};
  end

  // One wait cycle, then the answer for one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitReq_r <= 1'b1;
    end else if ((avs_read | avs_write) && waitReq_r) begin
      waitReq_r <= 1'b0;
    end else begin
      waitReq_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readData_r <= `RST_RDATA;
    end else if (avs_read && waitReq_r) begin
      readData_r <= 32'h00000000;
      if (inChannel) begin
        case (regOff)
          `REG_SRC_OFF: readData_r <= {8'h00, srcAddress_r[regCh]};
          `REG_DST_OFF: readData_r <= {8'h00, dstAddress_r[regCh]};
          `REG_COUNT_OFF: readData_r <= {16'h0000, blockSizeReload_r[regCh], blockRemainingCount_r[regCh]};
          `REG_BLKCNT_OFF: readData_r <= {16'h0000, blockCounter_r[regCh]};
          `REG_CTRL_OFF: readData_r <= {21'h000000, ctrl_r[regCh]};
          default: readData_r <= 32'h00000000;
        endcase
      end else begin
        case (avs_address)
          `REG_STATUS_OFF: readData_r <= {30'h00000000, status};
          `REG_MASK_OFF: readData_r <= {30'h00000000, mask};
          `REG_STATE_OFF: readData_r <= {24'h000000, activeCh_r, state_r};
          default: readData_r <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Activation and priority
  always_comb begin
    for (int i = 0; i < `DMA_CH_N; i++) begin
      // Auto request needs only the enable; USB request needs a low level
      pending[i] = ctrl_r[i].channelTransferEnable & (ctrl_r[i].autoRequest | ~reqLevel[i]);
    end
    actCtrl = ctrl_r[activeCh_r];
    if (!actCtrl.channelTransferEnable) begin
      continueXfer = 1'b0;
    end else if (actCtrl.blockMode) begin
      // A block never yields the bus midway
      continueXfer = ~blockEnd_r | (actCtrl.autoRequest & actCtrl.burstMode);
    end else begin
      continueXfer = actCtrl.autoRequest & actCtrl.burstMode;
    end
  end

  // ==========================================================
  // Transfer sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      activeCh_r <= 1'b0;
      busRequest_r <= 1'b0;
      memReq_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (|pending) begin
            activeCh_r <= ~pending[0];
            busRequest_r <= 1'b1;
            state_r <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (busGrant) begin
            memReq_r.addr <= srcAddress_r[activeCh_r];
            memReq_r.byteEn <= laneEnable(actCtrl.transferSizeSelect, srcAddress_r[activeCh_r][0]);
            memReq_r.read <= 1'b1;
            state_r <= ST_RD;
          end
        end
        ST_RD: begin
          if (!memWaitRequest) begin
            if (actCtrl.transferSizeSelect) begin
              memReq_r.wdata <= memReadData;
            end else if (srcAddress_r[activeCh_r][0]) begin
              memReq_r.wdata <= {memReadData[15:8], memReadData[15:8]};
            end else begin
              memReq_r.wdata <= {memReadData[7:0], memReadData[7:0]};
            end
            memReq_r.read <= 1'b0;
            memReq_r.write <= 1'b1;
            memReq_r.addr <= dstAddress_r[activeCh_r];
            memReq_r.byteEn <= laneEnable(actCtrl.transferSizeSelect, dstAddress_r[activeCh_r][0]);
            state_r <= ST_WR;
          end
        end
        ST_WR: begin
          if (!memWaitRequest) begin
            memReq_r.write <= 1'b0;
            state_r <= ST_STEP;
          end
        end
        ST_STEP: begin
          state_r <= ST_DECIDE;
        end
        ST_DECIDE: begin
          if (continueXfer) begin
            memReq_r.addr <= srcAddress_r[activeCh_r];
            memReq_r.byteEn <= laneEnable(actCtrl.transferSizeSelect, srcAddress_r[activeCh_r][0]);
            memReq_r.read <= 1'b1;
            state_r <= ST_RD;
          end else begin
            // Drop the bus so the CPU gets a cycle and the request level is looked at afresh
            busRequest_r <= 1'b0;
            state_r <= ST_REL;
          end
        end
        ST_REL: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
          busRequest_r <= 1'b0;
          memReq_r <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Channel registers: software writes, then hardware counting
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < `DMA_CH_N; i++) begin
        ctrl_r[i] <= channel_control_t'(`RST_CTRL);
        srcAddress_r[i] <= `RST_ADDR;
        dstAddress_r[i] <= `RST_ADDR;
        srcBase_r[i] <= `RST_ADDR;
        dstBase_r[i] <= `RST_ADDR;
        blockRemainingCount_r[i] <= `RST_COUNT8;
        blockSizeReload_r[i] <= `RST_COUNT8;
        blockCounter_r[i] <= `RST_COUNT16;
      end
      endEvent_r <= 2'h0;
      blockEnd_r <= 1'b0;
    end else begin
      endEvent_r <= 2'h0;
      if (wrAccess && inChannel) begin
        case (regOff)
          `REG_SRC_OFF: begin
            srcAddress_r[regCh] <= avs_writedata[`DMA_ADDR_W-1:0];
            srcBase_r[regCh] <= avs_writedata[`DMA_ADDR_W-1:0];
          end
          `REG_DST_OFF: begin
            dstAddress_r[regCh] <= avs_writedata[`DMA_ADDR_W-1:0];
            dstBase_r[regCh] <= avs_writedata[`DMA_ADDR_W-1:0];
          end
          `REG_COUNT_OFF: begin
            blockRemainingCount_r[regCh] <= avs_writedata[7:0];
            blockSizeReload_r[regCh] <= avs_writedata[15:8];
          end
          `REG_BLKCNT_OFF: blockCounter_r[regCh] <= avs_writedata[15:0];
          `REG_CTRL_OFF: ctrl_r[regCh] <= channel_control_t'(avs_writedata[`DMA_CTRL_W-1:0]);
          default: ;
        endcase
      end
      if (state_r == ST_STEP) begin
        blockEnd_r <= 1'b0;
        srcAddress_r[activeCh_r] <= stepAddr(srcAddress_r[activeCh_r], actCtrl.sourceStepEnable,
                                             actCtrl.sourceStepDirection, actCtrl.transferSizeSelect);
        dstAddress_r[activeCh_r] <= stepAddr(dstAddress_r[activeCh_r], actCtrl.destStepEnable,
                                             actCtrl.destStepDirection, actCtrl.transferSizeSelect);
        if (actCtrl.blockMode) begin
          blockRemainingCount_r[activeCh_r] <= blockRemainingCount_r[activeCh_r] - 8'h01;
          if (blockRemainingCount_r[activeCh_r] == 8'h01) begin
            blockRemainingCount_r[activeCh_r] <= blockSizeReload_r[activeCh_r];
            blockEnd_r <= 1'b1;
            // Block side goes back to the start address it was given
            if (actCtrl.blockSideSelect) begin
              srcAddress_r[activeCh_r] <= srcBase_r[activeCh_r];
            end else begin
              dstAddress_r[activeCh_r] <= dstBase_r[activeCh_r];
            end
            blockCounter_r[activeCh_r] <= blockCounter_r[activeCh_r] - 16'h0001;
            if (blockCounter_r[activeCh_r] == 16'h0001) begin
              ctrl_r[activeCh_r].channelTransferEnable <= 1'b0;
              endEvent_r[activeCh_r] <= 1'b1;
            end
          end
        end else begin
          blockCounter_r[activeCh_r] <= blockCounter_r[activeCh_r] - 16'h0001;
          if (blockCounter_r[activeCh_r] == 16'h0001) begin
            ctrl_r[activeCh_r].channelTransferEnable <= 1'b0;
            endEvent_r[activeCh_r] <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = readData_r;
  assign avs_waitrequest = waitReq_r;
  assign busRequest = busRequest_r;
  assign memReq = memReq_r;
endmodule // dma_block_and_request_transfer

// file: rtl/dma_cfg.svh
// Offsets, field positions, reset values and sizes for the two-channel DMA block
// Contract
// - In block mode each byte or word moved lowers the block remaining count by one.
// - One request bursts until remaining count is zero, then reloads from block size.
// - At block end restore the block-side address, honouring size, direction and step enable.
// - Each block lowers the block counter; at zero clear transfer enable and stop.
// - Transfer end with end interrupt enable set raises an interrupt request; the code also requires the channel's mask bit to be set.
// - In normal mode the USB request line activates transfers, sensed by level.
// - While the USB request line is high the channel idles awaiting a request.
// - While the USB request line is low transfer continuously, releasing bus per unit.
// - USB request returning high during transfer halts and waits for a new request.
// - Auto request starts on register setting alone; cycle steal or burst selectable.
// - Cycle steal releases the bus after every byte or word, alternating with CPU.
// - Burst mode holds the bus until the whole transfer is finished.
// - On bus release grant channel 0 before 1; never switch mid burst or block.
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

// ==========================================================
// Sizes
`define DMA_CH_N 2
`define DMA_ADDR_W 24
`define DMA_DATA_W 16
`define DMA_CTRL_W 11

// ==========================================================
// Register offsets
`define REG_SRC_OFF 5'h00
`define REG_DST_OFF 5'h04
`define REG_COUNT_OFF 5'h08
`define REG_BLKCNT_OFF 5'h0c
`define REG_CTRL_OFF 5'h10
`define REG_CH_BIT 5
`define REG_GLOBAL_BIT 6
`define REG_STATUS_OFF 8'h40
`define REG_MASK_OFF 8'h44
`define REG_STATE_OFF 8'h48

// ==========================================================
// Control field positions
`define CTRL_SIZE_WORD 0
`define CTRL_SRC_DIR 1
`define CTRL_DST_DIR 2
`define CTRL_SRC_EN 3
`define CTRL_DST_EN 4
`define CTRL_BLOCK_SIDE 5
`define CTRL_BLOCK_MODE 6
`define CTRL_AUTO_REQ 7
`define CTRL_BURST 8
`define CTRL_XFER_EN 9
`define CTRL_END_IE 10

// ==========================================================
// Reset values
`define RST_ADDR 24'h000000
`define RST_COUNT8 8'h00
`define RST_COUNT16 16'h0000
`define RST_CTRL 11'h000
`define RST_MASK 2'h0
`define RST_RDATA 32'h00000000

`endif

// file: rtl/dma_pkg.sv
// Types shared by the DMA block and its helpers
package dma_pkg;
  `include "dma_cfg.svh"

  typedef struct packed {
    logic endIntEnable;
    logic channelTransferEnable;
    logic burstMode;
    logic autoRequest;
    logic blockMode;
    logic blockSideSelect;
    logic destStepEnable;
    logic sourceStepEnable;
    logic destStepDirection;
    logic sourceStepDirection;
    logic transferSizeSelect;
  } channel_control_t;

  typedef struct packed {
    logic [`DMA_ADDR_W-1:0] addr;
    logic read;
    logic write;
    logic [`DMA_DATA_W-1:0] wdata;
    logic [1:0] byteEn;
  } mem_req_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ACQ = 7'h02,
    ST_RD = 7'h04,
    ST_WR = 7'h08,
    ST_STEP = 7'h10,
    ST_DECIDE = 7'h20,
    ST_REL = 7'h40
  } xfer_state_t;
endpackage

// file: rtl/req_sync.sv
// Two-flop synchroniser for the USB request lines
`timescale 1ns/1ps
module req_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] asyncIn,
  output logic [1:0] syncOut
);
  logic [1:0] stage1_r;
  logic [1:0] stage2_r;

  // Idle level is high, so reset to high to avoid a false request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1_r <= 2'h3;
      stage2_r <= 2'h3;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
    end
  end

  assign syncOut = stage2_r;
endmodule // req_sync

// file: rtl/dma_irq_ctrl.sv
// Sticky end-of-transfer status, mask and interrupt output
`timescale 1ns/1ps
`include "dma_cfg.svh"
module dma_irq_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] endEvent,
  input wire logic [1:0] endIntEnable,
  input wire logic [1:0] readClear,
  input wire logic maskWrite,
  input wire logic [1:0] maskData,
  output logic [1:0] status,
  output logic [1:0] mask,
  output logic irq
);
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic irq_r;
  logic [1:0] status_nxt;

  // Set wins over the read clear
  always_comb begin
    status_nxt = (status_r & ~readClear) | endEvent;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_r <= 2'h0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r <= `RST_MASK;
    end else if (maskWrite) begin
      mask_r <= maskData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_r & endIntEnable);
    end
  end

  assign status = status_r;
  assign mask = mask_r;
  assign irq = irq_r;
endmodule // dma_irq_ctrl

// file: testbench/dma_block_and_request_transfer_sva.sv
// Port checker for the DMA transfer sequencer
`timescale 1ns/1ps
module dma_block_and_request_transfer_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] usb_dma_request_n,
  input wire logic busRequest,
  input wire logic busGrant,
  input wire dma_pkg::mem_req_t memReq,
  input wire logic [15:0] memReadData,
  input wire logic memWaitRequest,
  input wire logic irq
);
  import dma_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Cycles since last completed write, saturating
  logic [3:0] sinceWr;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sinceWr <= 4'hf;
    end else if (memReq.write && !memWaitRequest) begin
      sinceWr <= 4'h0;
    end else if (sinceWr != 4'hf) begin
      sinceWr <= sinceWr + 4'h1;
    end
  end
  // ==========================================================
  // Assertions
  reg_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered next cycle");
  auto_start_a: assert property (avs_write && !avs_waitrequest && avs_address == 8'h10 && avs_writedata[9]
    && avs_writedata[7] && !busRequest |-> ##[1:4] busRequest) else $error("auto request did not start");
  bus_owned_a: assert property ((memReq.read || memReq.write) |-> busGrant && busRequest)
    else $error("memory access without bus ownership");
  one_kind_a: assert property (!(memReq.read && memReq.write))
    else $error("read and write together");
  read_then_write_a: assert property (memReq.read && !memWaitRequest |=> memReq.write && !memReq.read)
    else $error("completed read not followed by write");
  unit_step_a: assert property (memReq.write && !memWaitRequest |=> (!memReq.read && !memReq.write) [*2])
    else $error("no step and decide after a unit");
  request_hold_a: assert property ((memReq.read || memReq.write) && memWaitRequest |=> $stable(memReq))
    else $error("memory request changed while waiting");
  release_gap_a: assert property ($fell(busRequest) |-> !busRequest [*2])
    else $error("bus request back too soon");
  irq_cause_a: assert property ($rose(irq) |-> sinceWr < 4'h8)
    else $error("interrupt without a recent transfer end");
  cover property ($rose(irq));
  cover property (memReq.write && !memWaitRequest ##3 memReq.read);
  cover property ($fell(busRequest));
endmodule // dma_block_and_request_transfer_sva

bind dma_block_and_request_transfer dma_block_and_request_transfer_sva chk (
  .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .usb_dma_request_n, .busRequest, .busGrant, .memReq, .memReadData, .memWaitRequest, .irq
);

// file: testbench/sys_bus_model.sv
// Bus arbiter, wait-state memory and USB request source
`timescale 1ns/1ps
module sys_bus_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic busRequest,
  output logic busGrant,
  input wire dma_pkg::mem_req_t memReq,
  output logic [15:0] memReadData,
  output logic memWaitRequest,
  input wire logic [1:0] waitStates,
  input wire logic [1:0] usbWant,
  output logic [1:0] usb_dma_request_n
);
  import dma_pkg::*;
  logic [15:0] mem [64];
  logic [15:0] junk;
  logic [1:0] waitCnt;
  logic [5:0] idx;
  logic done;
  assign idx = memReq.addr[6:1];
  assign done = busGrant && (memReq.read || memReq.write) && waitCnt == waitStates;
  assign memWaitRequest = !done;
  // Toggling junk outside a read so stale data never passes
  assign memReadData = (done && memReq.read) ? mem[idx] : junk;
  assign usb_dma_request_n = ~usbWant;
  initial for (int i = 0; i < 64; i++) mem[i] = {2'b10, i[5:0], 2'b01, i[5:0]};
  always @(posedge ref_clk) begin
    busGrant <= !rst && busRequest;
    junk <= rst ? 16'h5a5a : ~junk;
    if (rst || done || !(memReq.read || memReq.write)) begin
      waitCnt <= 2'h0;
    end else begin
      waitCnt <= waitCnt + 2'h1;
    end
    if (done && memReq.write && memReq.byteEn[0]) mem[idx][7:0] <= memReq.wdata[7:0];
    if (done && memReq.write && memReq.byteEn[1]) mem[idx][15:8] <= memReq.wdata[15:8];
  end
endmodule // sys_bus_model

// file: testbench/dma_block_and_request_transfer_test.sv
// Self-checking bench for the DMA transfer sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin errors++; $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module dma_block_and_request_transfer_test;
  import dma_pkg::*;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, busRequest, busGrant, memWaitRequest, irq, prevBr;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [1:0] usb_dma_request_n, usbWant, waitStates;
  logic [15:0] memReadData;
  mem_req_t memReq;
  int errors = 0, samplesChecked = 0, units = 0, tenures = 0, cyc = 0;

  dma_block_and_request_transfer dut (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .usb_dma_request_n(usb_dma_request_n), .busRequest(busRequest), .busGrant(busGrant), .memReq(memReq),
    .memReadData(memReadData), .memWaitRequest(memWaitRequest), .irq(irq));
  sys_bus_model mdl (
    .ref_clk(ref_clk), .rst(rst), .busRequest(busRequest), .busGrant(busGrant), .memReq(memReq),
    .memReadData(memReadData), .memWaitRequest(memWaitRequest), .waitStates(waitStates), .usbWant(usbWant),
    .usb_dma_request_n(usb_dma_request_n));

  // ==========================================================
  // Clock, timeout and traffic monitor
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  always @(posedge ref_clk) begin
    if (memReq.write && !memWaitRequest) units <= units + 1;
    if (busRequest && !prevBr) tenures <= tenures + 1;
    prevBr <= busRequest;
  end

  // ==========================================================
  // Register access and helpers
  function automatic logic [15:0] memVal(input int i);
    return {2'b10, i[5:0], 2'b01, i[5:0]};
  endfunction
  task automatic avAcc(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    // Only the bench timeout ends a hung access
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic avWr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    avAcc(1'b1, a, wd, x);
  endtask
  task automatic avRd(input logic [7:0] a, output logic [31:0] rd);
    avAcc(1'b0, a, 32'h0, rd);
  endtask
  // Control written last because it starts the channel
  task automatic cfg(input logic [7:0] b, input logic [23:0] s, input logic [23:0] t, input logic [15:0] c,
                     input logic [15:0] k, input logic [10:0] ctl);
    avWr(b, {8'h00, s});
    avWr(b + 8'h04, {8'h00, t});
    avWr(b + 8'h08, {16'h0, c});
    avWr(b + 8'h0c, {16'h0, k});
    units = 0;
    tenures = 0;
    avWr(b + 8'h10, {21'h0, ctl});
  endtask
  task automatic waitDone(input logic [7:0] b);
    d = 32'h200;
    while (d[9] !== 1'b0) begin
      avRd(b + 8'h10, d);
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic wrap_up();
    if (errors == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    usbWant = 2'h0;
    waitStates = 2'h0;
    prevBr = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    avRd(8'h10, d); `CHK(d, 32'h0);
    avRd(8'h48, d); `CHK(d, 32'h1);
    avWr(8'h14, 32'hffff); avRd(8'h14, d); `CHK(d, 32'h0);
    // Auto request, burst, word, interrupt unmasked
    avWr(8'h44, 32'h1);
    cfg(8'h00, 24'h0, 24'h40, 16'h0, 16'h4, 11'h799);
    waitDone(8'h00);
    `CHK(units, 4);
    `CHK(tenures, 1);
    `CHK(irq, 1'b1);
    avRd(8'h0c, d); `CHK(d, 32'h0);
    for (int i = 0; i < 4; i++) `CHK(mdl.mem[32 + i], memVal(i));
    avRd(8'h40, d); `CHK(d, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0);
    avRd(8'h40, d); `CHK(d, 32'h0);
    // Auto request, cycle steal, slow memory, interrupt masked
    avWr(8'h44, 32'h0);
    waitStates <= 2'h2;
    cfg(8'h00, 24'h8, 24'h50, 16'h0, 16'h3, 11'h699);
    waitDone(8'h00);
    `CHK(tenures, 3);
    `CHK(irq, 1'b0);
    avRd(8'h40, d); `CHK(d, 32'h1);
    for (int i = 0; i < 3; i++) `CHK(mdl.mem[40 + i], memVal(4 + i));
    avWr(8'h44, 32'h1); avRd(8'h44, d); `CHK(d, 32'h1);
    // Block mode, byte, source side restored, two blocks of two
    waitStates <= 2'h0;
    cfg(8'h00, 24'h10, 24'h60, 16'h0202, 16'h2, 11'h3f8);
    waitDone(8'h00);
    `CHK(units, 4);
    `CHK(tenures, 1);
    `CHK(mdl.mem[48], memVal(8));
    `CHK(mdl.mem[49], memVal(8));
    avRd(8'h00, d); `CHK(d, 32'h10);
    avRd(8'h04, d); `CHK(d, 32'h64);
    avRd(8'h08, d); `CHK(d, 32'h0202);
    avRd(8'h0c, d); `CHK(d, 32'h0);
    avRd(8'h40, d); `CHK(d, 32'h1);
    // USB request on channel 1, halted mid transfer then resumed
    cfg(8'h20, 24'h20, 24'h70, 16'h0, 16'h3, 11'h219);
    repeat (20) @(posedge ref_clk);
    `CHK(tenures, 0);
    usbWant[1] <= 1'b1;
    while (units == 0) @(posedge ref_clk);
    usbWant[1] <= 1'b0;
    repeat (20) @(posedge ref_clk);
    `CHK(units <= 2, 1'b1);
    `CHK(busRequest, 1'b0);
    avRd(8'h30, d); `CHK(d[9], 1'b1);
    usbWant[1] <= 1'b1;
    waitDone(8'h20);
    usbWant[1] <= 1'b0;
    `CHK(units, 3);
    `CHK(tenures, 3);
    for (int i = 0; i < 3; i++) `CHK(mdl.mem[56 + i], memVal(16 + i));
    // Both channels requested at once onto one word; the last writer must be channel 1
    cfg(8'h00, 24'h0, 24'h7e, 16'h0, 16'h2, 11'h209);
    cfg(8'h20, 24'h16, 24'h7e, 16'h0, 16'h2, 11'h20b);
    usbWant <= 2'h3;
    waitDone(8'h20);
    usbWant <= 2'h0;
    `CHK(mdl.mem[63], memVal(10));
    `CHK(units, 4);
    avRd(8'h48, d); `CHK(d, 32'h81);
    avRd(8'h20, d); `CHK(d, 32'h12);
    wrap_up();
  end
endmodule // dma_block_and_request_transfer_test
